/* File: fpdc_pkg.sv */
package fpdc_pkg;
  // device register map, byte addresses on the device port
  localparam logic [31:0] CODE_CTRL_ADDR = 32'hFFFF_E000;
  localparam logic [31:0] PROG_SEL_ADDR = 32'hFFFF_E004;
  localparam logic [31:0] ERASE_SEL_ADDR = 32'hFFFF_E008;
  localparam logic [31:0] KEY_ADDR = 32'hFFFF_E00C;
  localparam logic [31:0] DEST_REG_ADDR = 32'hFFFF_E010;
  localparam logic [31:0] VECTOR_BASE_ADDR = 32'hFFFF_E014;
  // field positions
  localparam int DL_REQ_BIT = 0;
  localparam int PROG_SEL_BIT = 0;
  localparam int DERR_BIT = 7;
  localparam int SERR_BIT = 2;
  localparam int KERR_BIT = 1;
  // values
  localparam logic [31:0] KEY_DOWNLOAD = 32'h0000_00A5;
  localparam logic [31:0] KEY_PROGRAM = 32'h0000_005A;
  localparam logic [31:0] KEY_CLEAR = 32'h0000_0000;
  localparam logic [31:0] VB_VALUE = 32'h8400_0000;
  localparam logic [31:0] RESULT_PRESET_WORD = 32'h0000_00FF;
  localparam logic [7:0] RESULT_PRESET = 8'hFF;
  localparam logic [7:0] RESULT_OK = 8'h00;
  localparam logic [31:0] PAD_WORD = 32'hFFFF_FFFF;
  localparam logic [31:0] PASS_BYTES = 32'h0000_0080;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] INIT_OFS = 32'h0000_0020;
  localparam logic [31:0] PROG_OFS = 32'h0000_0010;
  localparam logic [31:0] STACK_MIN = 32'h0000_0080;
  localparam logic [2:0] NOP_LAST = 3'h3;
  localparam logic [3:0] SEL_ALL = 4'hF;
  localparam logic [3:0] SEL_LOW = 4'h1;
  // wishbone register offsets
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_STATUS = 8'h04;
  localparam logic [7:0] WB_DEST = 8'h08;
  localparam logic [7:0] WB_FADDR = 8'h0C;
  localparam logic [7:0] WB_SRC = 8'h10;
  localparam logic [7:0] WB_LEN = 8'h14;
  localparam logic [7:0] WB_FREQ = 8'h18;
  localparam logic [7:0] WB_UBR = 8'h1C;
  localparam logic [7:0] WB_STACK = 8'h20;
  localparam logic [7:0] WB_RET = 8'h24;
  // error codes
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_SELECT = 3'h1;
  localparam logic [2:0] ERR_KEY = 3'h2;
  localparam logic [2:0] ERR_DEST = 3'h3;
  localparam logic [2:0] ERR_INIT = 3'h4;
  localparam logic [2:0] ERR_PROG = 3'h5;
  localparam logic [2:0] ERR_REFUSED = 3'h6;

  typedef enum logic [16:0] {
    S_IDLE = 17'h00001,
    S_SEL = 17'h00002,
    S_ESEL = 17'h00004,
    S_DEST = 17'h00008,
    S_KEYA = 17'h00010,
    S_VECT = 17'h00020,
    S_PRE = 17'h00040,
    S_REQ = 17'h00080,
    S_NOP = 17'h00100,
    S_RES = 17'h00200,
    S_KEYZ = 17'h00400,
    S_TDR = 17'h00800,
    S_INIT = 17'h01000,
    S_KEYP = 17'h02000,
    S_PASS = 17'h04000,
    S_PAD = 17'h08000,
    S_PROG = 17'h10000
  } fpdc_state_type;
endpackage

/* File: fpdc_host.sv */
// Summary of operation
// - program in 128-byte passes, advance both pointers, pad short tail with ones.
// - request only with RAM emulation off, key loaded, issued from RAM.
// - load vector base with fixed value before requesting download.
// - preset result byte to a non-return value before requesting.
// - let four idle instruction slots pass after the request write.
// - keep other bus masters off the bus during download.
// - reserve at least 128 bytes of stack before requesting.
// - clear the key register to zero after the download returns.
// - pass zero user-branch address when no branch is wanted.
// - load programming key before calling the programming routine.
//
// Design decisions made here: register access over Wishbone and the register offsets.
module fpdc_host (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // device register and RAM port
  output logic dev_req_o,
  output logic dev_we_o,
  output logic [31:0] dev_addr_o,
  output logic [31:0] dev_wdata_o,
  output logic [3:0] dev_sel_o,
  input wire logic dev_ack_i,
  input wire logic [31:0] dev_rdata_i,
  // routine call port
  output logic call_req_o,
  output logic [31:0] call_addr_o,
  output logic [31:0] call_arg4_o,
  output logic [31:0] call_arg5_o,
  input wire logic call_done_i,
  input wire logic [31:0] call_ret_i,
  // system
  input wire logic ram_emulation_i,
  output logic bus_hold_o
);

  typedef struct packed {
    fpdc_pkg::fpdc_state_type st;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic dev_req;
    logic dev_we;
    logic [31:0] dev_addr;
    logic [31:0] dev_wdata;
    logic [3:0] dev_sel;
    logic call_req;
    logic [31:0] call_addr;
    logic [31:0] call_arg4;
    logic [31:0] call_arg5;
    logic bus_hold;
    logic [31:0] dest;
    logic [31:0] faddr;
    logic [31:0] src;
    logic [31:0] len;
    logic [31:0] freq;
    logic [31:0] ubr;
    logic [31:0] stack;
    logic [31:0] ret;
    logic [31:0] rem;
    logic [31:0] pad;
    logic [7:0] result;
    logic [2:0] err;
    logic derr;
    logic busy;
    logic done;
    logic [2:0] cnt;
  } fpdc_regs_type;

  fpdc_regs_type s;
  fpdc_regs_type next_s;

  function automatic logic [31:0] fpdc_merge(input logic [31:0] old, input logic [31:0] val,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic op_go;
  logic op_we;
  logic [31:0] op_addr;
  logic [31:0] op_data;
  logic [3:0] op_sel;
  logic op_done;
  logic call_fin;
  logic [31:0] status;
  logic [31:0] pass_len;

  always_comb begin
    next_s = s;
    op_go = 1'b0;
    op_we = 1'b1;
    op_addr = 32'h0000_0000;
    op_data = 32'h0000_0000;
    op_sel = fpdc_pkg::SEL_ALL;
    op_done = s.dev_req && dev_ack_i;
    call_fin = s.call_req && call_done_i;
    pass_len = (s.rem < fpdc_pkg::PASS_BYTES) ? s.rem : fpdc_pkg::PASS_BYTES;
    status = {16'h0000, s.result, 2'b00, s.derr, s.err, s.done, s.busy};
    next_s.wb_ack = 1'b0;

    // wishbone slave, one wait cycle, ack dropped after one cycle
    if (wb_cyc_i && wb_stb_i && !s.wb_ack) begin
      next_s.wb_ack = 1'b1;
      case (wb_adr_i)
        fpdc_pkg::WB_STATUS: next_s.wb_dat = status;
        fpdc_pkg::WB_DEST: next_s.wb_dat = s.dest;
        fpdc_pkg::WB_FADDR: next_s.wb_dat = s.faddr;
        fpdc_pkg::WB_SRC: next_s.wb_dat = s.src;
        fpdc_pkg::WB_LEN: next_s.wb_dat = s.len;
        fpdc_pkg::WB_FREQ: next_s.wb_dat = s.freq;
        fpdc_pkg::WB_UBR: next_s.wb_dat = s.ubr;
        fpdc_pkg::WB_STACK: next_s.wb_dat = s.stack;
        fpdc_pkg::WB_RET: next_s.wb_dat = s.ret;
        default: next_s.wb_dat = 32'h0000_0000;
      endcase
      // configuration is frozen while a job runs
      if (wb_we_i && !s.busy) begin
        case (wb_adr_i)
          fpdc_pkg::WB_DEST: next_s.dest = fpdc_merge(s.dest, wb_dat_i, wb_sel_i);
          fpdc_pkg::WB_FADDR: next_s.faddr = fpdc_merge(s.faddr, wb_dat_i, wb_sel_i);
          fpdc_pkg::WB_SRC: next_s.src = fpdc_merge(s.src, wb_dat_i, wb_sel_i);
          fpdc_pkg::WB_LEN: next_s.len = fpdc_merge(s.len, wb_dat_i, wb_sel_i);
          fpdc_pkg::WB_FREQ: next_s.freq = fpdc_merge(s.freq, wb_dat_i, wb_sel_i);
          fpdc_pkg::WB_UBR: next_s.ubr = fpdc_merge(s.ubr, wb_dat_i, wb_sel_i);
          fpdc_pkg::WB_STACK: next_s.stack = fpdc_merge(s.stack, wb_dat_i, wb_sel_i);
          fpdc_pkg::WB_CTRL: begin
            if (wb_sel_i[0] && wb_dat_i[0]) begin
              next_s.done = 1'b0;
              next_s.err = fpdc_pkg::ERR_NONE;
              next_s.derr = 1'b0;
              next_s.result = 8'h00;
              next_s.ret = 32'h0000_0000;
              if (ram_emulation_i || (s.stack < fpdc_pkg::STACK_MIN) || (s.len == 0)) begin
                next_s.err = fpdc_pkg::ERR_REFUSED;
                next_s.done = 1'b1;
              end else begin
                next_s.busy = 1'b1;
                next_s.rem = s.len;
                next_s.st = fpdc_pkg::S_SEL;
              end
            end
          end
          default: ;
        endcase
      end
    end

    case (s.st)
      fpdc_pkg::S_IDLE: ;
      fpdc_pkg::S_SEL: begin
        op_go = 1'b1;
        op_addr = fpdc_pkg::PROG_SEL_ADDR;
        op_data = 32'h0000_0001 << fpdc_pkg::PROG_SEL_BIT;
        if (op_done) begin
          next_s.st = fpdc_pkg::S_ESEL;
        end
      end
      fpdc_pkg::S_ESEL: begin
        // only the programming routine may be selected
        op_go = 1'b1;
        op_addr = fpdc_pkg::ERASE_SEL_ADDR;
        if (op_done) begin
          next_s.st = fpdc_pkg::S_DEST;
        end
      end
      fpdc_pkg::S_DEST: begin
        op_go = 1'b1;
        op_addr = fpdc_pkg::DEST_REG_ADDR;
        op_data = s.dest;
        if (op_done) begin
          next_s.st = fpdc_pkg::S_KEYA;
        end
      end
      fpdc_pkg::S_KEYA: begin
        op_go = 1'b1;
        op_addr = fpdc_pkg::KEY_ADDR;
        op_data = fpdc_pkg::KEY_DOWNLOAD;
        if (op_done) begin
          next_s.st = fpdc_pkg::S_VECT;
        end
      end
      fpdc_pkg::S_VECT: begin
        op_go = 1'b1;
        op_addr = fpdc_pkg::VECTOR_BASE_ADDR;
        op_data = fpdc_pkg::VB_VALUE;
        if (op_done) begin
          next_s.st = fpdc_pkg::S_PRE;
        end
      end
      fpdc_pkg::S_PRE: begin
        op_go = 1'b1;
        op_addr = s.dest;
        op_data = fpdc_pkg::RESULT_PRESET_WORD;
        op_sel = fpdc_pkg::SEL_LOW;
        if (op_done) begin
          next_s.st = fpdc_pkg::S_REQ;
          next_s.bus_hold = 1'b1;
        end
      end
      fpdc_pkg::S_REQ: begin
        op_go = 1'b1;
        op_addr = fpdc_pkg::CODE_CTRL_ADDR;
        op_data = 32'h0000_0001 << fpdc_pkg::DL_REQ_BIT;
        if (op_done) begin
          next_s.st = fpdc_pkg::S_NOP;
          next_s.cnt = 3'h0;
        end
      end
      fpdc_pkg::S_NOP: begin
        next_s.cnt = s.cnt + 3'h1;
        if (s.cnt == fpdc_pkg::NOP_LAST) begin
          next_s.st = fpdc_pkg::S_RES;
        end
      end
      fpdc_pkg::S_RES: begin
        // request bit is not polled: it never reads back as one
        op_go = 1'b1;
        op_we = 1'b0;
        op_addr = s.dest;
        if (op_done) begin
          next_s.result = dev_rdata_i[7:0];
          next_s.bus_hold = 1'b0;
          next_s.st = fpdc_pkg::S_KEYZ;
        end
      end
      fpdc_pkg::S_KEYZ: begin
        op_go = 1'b1;
        op_addr = fpdc_pkg::KEY_ADDR;
        op_data = fpdc_pkg::KEY_CLEAR;
        if (op_done) begin
          if (s.result == fpdc_pkg::RESULT_OK) begin
            next_s.st = fpdc_pkg::S_INIT;
          end else if (s.result == fpdc_pkg::RESULT_PRESET) begin
            next_s.st = fpdc_pkg::S_TDR;
          end else begin
            next_s.err = s.result[fpdc_pkg::SERR_BIT] ? fpdc_pkg::ERR_SELECT
                                                    : fpdc_pkg::ERR_KEY;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.st = fpdc_pkg::S_IDLE;
          end
        end
      end
      fpdc_pkg::S_TDR: begin
        op_go = 1'b1;
        op_we = 1'b0;
        op_addr = fpdc_pkg::DEST_REG_ADDR;
        if (op_done) begin
          next_s.derr = dev_rdata_i[fpdc_pkg::DERR_BIT];
          next_s.err = fpdc_pkg::ERR_DEST;
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
          next_s.st = fpdc_pkg::S_IDLE;
        end
      end
      fpdc_pkg::S_INIT: begin
        if (!s.call_req) begin
          next_s.call_req = 1'b1;
          next_s.call_addr = s.dest + fpdc_pkg::INIT_OFS;
          next_s.call_arg4 = s.freq;
          next_s.call_arg5 = s.ubr;
        end else if (call_fin) begin
          next_s.call_req = 1'b0;
          next_s.ret = call_ret_i;
          if (call_ret_i != 32'h0000_0000) begin
            next_s.err = fpdc_pkg::ERR_INIT;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.st = fpdc_pkg::S_IDLE;
          end else begin
            next_s.st = fpdc_pkg::S_KEYP;
          end
        end
      end
      fpdc_pkg::S_KEYP: begin
        op_go = 1'b1;
        op_addr = fpdc_pkg::KEY_ADDR;
        op_data = fpdc_pkg::KEY_PROGRAM;
        if (op_done) begin
          next_s.st = fpdc_pkg::S_PASS;
        end
      end
      fpdc_pkg::S_PASS: begin
        next_s.pad = s.src + s.rem;
        if (s.rem < fpdc_pkg::PASS_BYTES) begin
          next_s.st = fpdc_pkg::S_PAD;
        end else begin
          next_s.st = fpdc_pkg::S_PROG;
        end
      end
      fpdc_pkg::S_PAD: begin
        // tail of a short pass is filled with erased-state words
        op_go = 1'b1;
        op_addr = s.pad;
        op_data = fpdc_pkg::PAD_WORD;
        if (op_done) begin
          next_s.pad = s.pad + fpdc_pkg::WORD_BYTES;
          if (s.pad + fpdc_pkg::WORD_BYTES >= s.src + fpdc_pkg::PASS_BYTES) begin
            next_s.st = fpdc_pkg::S_PROG;
          end
        end
      end
      fpdc_pkg::S_PROG: begin
        if (!s.call_req) begin
          next_s.call_req = 1'b1;
          next_s.bus_hold = 1'b1;
          next_s.call_addr = s.dest + fpdc_pkg::PROG_OFS;
          next_s.call_arg4 = s.src;
          next_s.call_arg5 = s.faddr;
        end else if (call_fin) begin
          next_s.call_req = 1'b0;
          next_s.bus_hold = 1'b0;
          next_s.ret = call_ret_i;
          next_s.src = s.src + fpdc_pkg::PASS_BYTES;
          next_s.faddr = s.faddr + fpdc_pkg::PASS_BYTES;
          next_s.rem = s.rem - pass_len;
          next_s.st = fpdc_pkg::S_KEYZ;
          if (call_ret_i != 32'h0000_0000) begin
            next_s.err = fpdc_pkg::ERR_PROG;
            next_s.rem = 32'h0000_0000;
          end else if (s.rem != pass_len) begin
            next_s.st = fpdc_pkg::S_PASS;
          end
        end
      end
      default: next_s.st = fpdc_pkg::S_IDLE;
    endcase

    // after the last pass the key is cleared through the same state
    if (s.st == fpdc_pkg::S_KEYZ && s.rem == 32'h0000_0000 && op_done) begin
      next_s.result = RESULT_OK_OR(s);
      next_s.busy = 1'b0;
      next_s.done = 1'b1;
      next_s.st = fpdc_pkg::S_IDLE;
    end

    if (op_go && !s.dev_req) begin
      next_s.dev_req = 1'b1;
      next_s.dev_we = op_we;
      next_s.dev_addr = op_addr;
      next_s.dev_wdata = op_data;
      next_s.dev_sel = op_sel;
    end
    if (op_done) begin
      next_s.dev_req = 1'b0;
    end
  end

  function automatic logic [7:0] RESULT_OK_OR(input fpdc_regs_type r);
    return (r.err == fpdc_pkg::ERR_NONE) ? fpdc_pkg::RESULT_OK : r.result;
  endfunction

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
      s.st <= fpdc_pkg::S_IDLE;
      s.stack <= fpdc_pkg::STACK_MIN;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.wb_ack;
  assign wb_dat_o = s.wb_dat;
  assign dev_req_o = s.dev_req;
  assign dev_we_o = s.dev_we;
  assign dev_addr_o = s.dev_addr;
  assign dev_wdata_o = s.dev_wdata;
  assign dev_sel_o = s.dev_sel;
  assign call_req_o = s.call_req;
  assign call_addr_o = s.call_addr;
  assign call_arg4_o = s.call_arg4;
  assign call_arg5_o = s.call_arg5;
  assign bus_hold_o = s.bus_hold;

endmodule // fpdc_host

/* File: fpdc_host_sva.sv */
module fpdc_host_sva (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // device port
  input wire logic dev_req_o,
  input wire logic dev_we_o,
  input wire logic [31:0] dev_addr_o,
  input wire logic [31:0] dev_wdata_o,
  input wire logic dev_ack_i,
  // call port
  input wire logic call_req_o,
  input wire logic [31:0] call_addr_o,
  input wire logic call_done_i,
  // system
  input wire logic ram_emulation_i,
  input wire logic bus_hold_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  logic vba_ok;
  sequence dl_req;
    dev_req_o && dev_we_o && dev_addr_o == fpdc_pkg::CODE_CTRL_ADDR;
  endsequence
  sequence dl_end;
    dl_req ##0 dev_ack_i;
  endsequence
  // remembers whether the vector base was loaded with VB_VALUE since the last request
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vba_ok <= 1'b0;
    end else if (dev_req_o && dev_ack_i && dev_we_o) begin
      if (dev_addr_o == fpdc_pkg::VECTOR_BASE_ADDR) begin
        vba_ok <= dev_wdata_o == fpdc_pkg::VB_VALUE;
      end else if (dev_addr_o == fpdc_pkg::CODE_CTRL_ADDR) begin
        vba_ok <= 1'b0;
      end
    end
  end
  wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("wishbone ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("wishbone ack longer than one cycle");
  dev_hold_a: assert property (dev_req_o && !dev_ack_i |=> dev_req_o && $stable(dev_addr_o)
    && $stable(dev_wdata_o) && $stable(dev_we_o)) else $error("device request not held");
  dev_release_a: assert property (dev_req_o && dev_ack_i |=> !dev_req_o)
    else $error("device request not released after ack");
  call_hold_a: assert property (call_req_o && !call_done_i |=> call_req_o && $stable(call_addr_o))
    else $error("call request not held");
  call_release_a: assert property (call_req_o && call_done_i |=> !call_req_o)
    else $error("call request not released after done");
  nop_gap_a: assert property (dl_end |=> !dev_req_o [*4])
    else $error("access too soon after download request");
  dl_hold_a: assert property (dl_req |-> bus_hold_o && !ram_emulation_i)
    else $error("download requested without bus hold or with emulation on");
  vba_first_a: assert property (dl_req |-> vba_ok)
    else $error("download requested before vector base load");
endmodule // fpdc_host_sva

/* File: fpdc_dev_model.sv */
module fpdc_dev_model #(
  parameter logic [31:0] FREQ_MIN = 32'h0000_03E8,
  parameter logic [31:0] FREQ_MAX = 32'h0000_1F40,
  parameter logic [31:0] USER_END = 32'h0004_0000
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // device port
  input wire logic dev_req_i,
  input wire logic dev_we_i,
  input wire logic [31:0] dev_addr_i,
  input wire logic [31:0] dev_wdata_i,
  input wire logic [3:0] dev_sel_i,
  output logic dev_ack_o,
  output logic [31:0] dev_rdata_o,
  // routine call port
  input wire logic call_req_i,
  input wire logic [31:0] call_addr_i,
  input wire logic [31:0] call_arg4_i,
  input wire logic [31:0] call_arg5_i,
  output logic call_done_o,
  output logic [31:0] call_ret_o,
  // environment
  input wire logic ram_emulation_i,
  input wire logic bus_hold_i,
  input wire logic slow_i,
  input wire logic sel_fault_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ram [logic [31:0]];
  logic [31:0] flash [logic [31:0]];
  logic [31:0] dest, vba, w;
  logic [7:0] key;
  logic prog_sel, erase_sel, derr;
  int viol = 0, passes = 0, dwait, cwait;
  function automatic logic in_ram(input logic [31:0] a);
    return a[31:16] == 16'hFFFF;
  endfunction
  task automatic download();
    if (vba !== fpdc_pkg::VB_VALUE || bus_hold_i !== 1'b1 || ram[dest][7:0] !== 8'hFF) viol++;
    if (prog_sel && erase_sel) ram[dest][7:0] = 8'h01 << fpdc_pkg::SERR_BIT;
    else if (!in_ram(dest)) derr = 1'b1;
    else ram[dest][7:0] = fpdc_pkg::RESULT_OK;
    prog_sel = 1'b0;
    erase_sel = 1'b0;
  endtask
  function automatic logic [31:0] routine();
    if (call_addr_i == dest + fpdc_pkg::INIT_OFS)
      return (call_arg4_i < FREQ_MIN || call_arg4_i > FREQ_MAX) ? 32'h1 : 32'h0;
    if (call_addr_i != dest + fpdc_pkg::PROG_OFS || key != 8'h5A) viol++;
    if (call_arg5_i >= USER_END || call_arg5_i[6:0] != 7'h00) return 32'h1;
    if (!in_ram(call_arg4_i)) return 32'h1;
    for (int i = 0; i < 32; i++) flash[call_arg5_i + 4 * i] = ram[call_arg4_i + 4 * i];
    passes++;
    return 32'h0;
  endfunction
  // released read data toggles so a stale word is never mistaken for an answer
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dev_ack_o <= 1'b0;
      dev_rdata_o <= 32'h0;
      key = 8'h00;
      prog_sel = 1'b0;
      erase_sel = 1'b0;
      derr = 1'b0;
      dwait = 0;
    end else if (dev_req_i && !dev_ack_o && dwait < (slow_i ? 3 : 0)) begin
      dwait++;
      dev_rdata_o <= ~dev_rdata_o;
    end else if (dev_req_i && !dev_ack_o) begin
      dwait = 0;
      dev_ack_o <= 1'b1;
      if (dev_we_i) begin
        case (dev_addr_i)
          fpdc_pkg::PROG_SEL_ADDR: prog_sel = dev_wdata_i[fpdc_pkg::PROG_SEL_BIT];
          fpdc_pkg::ERASE_SEL_ADDR: erase_sel = dev_wdata_i[0] | sel_fault_i;
          fpdc_pkg::KEY_ADDR: key = dev_wdata_i[7:0];
          fpdc_pkg::VECTOR_BASE_ADDR: vba = dev_wdata_i;
          fpdc_pkg::DEST_REG_ADDR: begin
            dest = dev_wdata_i;
            derr = 1'b0;
          end
          fpdc_pkg::CODE_CTRL_ADDR: if (dev_wdata_i[0] && key == 8'hA5 && !ram_emulation_i) download();
          default: begin
            w = ram.exists(dev_addr_i) ? ram[dev_addr_i] : 32'h0;
            for (int b = 0; b < 4; b++) if (dev_sel_i[b]) w[8 * b +: 8] = dev_wdata_i[8 * b +: 8];
            ram[dev_addr_i] = w;
          end
        endcase
      end else if (dev_addr_i == fpdc_pkg::DEST_REG_ADDR) dev_rdata_o <= {dest[31:8], derr, dest[6:0]};
      else if (dev_addr_i == fpdc_pkg::CODE_CTRL_ADDR) dev_rdata_o <= 32'h0;
      else dev_rdata_o <= ram.exists(dev_addr_i) ? ram[dev_addr_i] : 32'h0;
    end else begin
      dev_ack_o <= 1'b0;
      dev_rdata_o <= ~dev_rdata_o;
    end
  end
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      call_done_o <= 1'b0;
      call_ret_o <= 32'h0;
      cwait = 0;
    end else if (call_req_i && !call_done_o && cwait < (slow_i ? 5 : 1)) cwait++;
    else if (call_req_i && !call_done_o) begin
      cwait = 0;
      call_done_o <= 1'b1;
      call_ret_o <= routine();
    end else begin
      call_done_o <= 1'b0;
      call_ret_o <= ~call_ret_o;
    end
  end
endmodule // fpdc_dev_model

/* File: tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] FMIN = 32'h0000_03E8;
  localparam logic [31:0] FMAX = 32'h0000_1F40;
  typedef struct {
    logic [31:0] dest, faddr, src, len, freq, stack;
    logic emu, selfault;
  } fpdc_case_type;
  logic clock_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow, sel_fault;
  logic dev_req_o, dev_we_o, dev_ack_i, call_req_o, call_done_i, ram_emulation_i, bus_hold_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, dev_sel_o;
  logic [31:0] wb_dat_i, wb_dat_o, dev_addr_o, dev_wdata_o, dev_rdata_i, rd, w;
  logic [31:0] call_addr_o, call_arg4_o, call_arg5_o, call_ret_i;
  logic [31:0] seed = 32'h7297597B;
  logic [31:0] exp_q [$];
  logic [2:0] e;
  int error_cnt = 0, check_count = 0, cycles = 0, acks = 0, a0, p0, n;
  fpdc_case_type c;
  fpdc_host DUT (.clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .dev_req_o(dev_req_o), .dev_we_o(dev_we_o),
    .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_sel_o(dev_sel_o),
    .dev_ack_i(dev_ack_i), .dev_rdata_i(dev_rdata_i), .call_req_o(call_req_o),
    .call_addr_o(call_addr_o), .call_arg4_o(call_arg4_o), .call_arg5_o(call_arg5_o),
    .call_done_i(call_done_i), .call_ret_i(call_ret_i), .ram_emulation_i(ram_emulation_i),
    .bus_hold_o(bus_hold_o));
  fpdc_dev_model #(.FREQ_MIN(FMIN), .FREQ_MAX(FMAX)) DEV (.clock_i(clock_i), .rstn_i(rstn_i),
    .dev_req_i(dev_req_o), .dev_we_i(dev_we_o), .dev_addr_i(dev_addr_o),
    .dev_wdata_i(dev_wdata_o), .dev_sel_i(dev_sel_o), .dev_ack_o(dev_ack_i),
    .dev_rdata_o(dev_rdata_i), .call_req_i(call_req_o), .call_addr_i(call_addr_o),
    .call_arg4_i(call_arg4_o), .call_arg5_i(call_arg5_o), .call_done_o(call_done_i),
    .call_ret_o(call_ret_i), .ram_emulation_i(ram_emulation_i), .bus_hold_i(bus_hold_o),
    .slow_i(slow), .sel_fault_i(sel_fault));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] exp_err(input fpdc_case_type c);
    if (c.emu || c.stack < fpdc_pkg::STACK_MIN || c.len == 0) return fpdc_pkg::ERR_REFUSED;
    if (c.selfault) return fpdc_pkg::ERR_SELECT;
    if (c.dest[31:16] != 16'hFFFF) return fpdc_pkg::ERR_DEST;
    if (c.freq < FMIN || c.freq > FMAX) return fpdc_pkg::ERR_INIT;
    if (c.faddr[6:0] != 7'h00 || c.src[31:16] != 16'hFFFF) return fpdc_pkg::ERR_PROG;
    return fpdc_pkg::ERR_NONE;
  endfunction
  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      error_cnt++;
      $display("MISMATCH time %0t got %h expected %h", $time, got, want);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // hang guard and count of device answers
  always @(posedge clock_i) begin
    cycles++;
    if (dev_ack_i === 1'b1) acks++;
    if (cycles == 60000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    {rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, ram_emulation_i, slow, sel_fault} = '0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = fpdc_pkg::SEL_ALL;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    wb(1'b0, fpdc_pkg::WB_STATUS, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, fpdc_pkg::WB_STACK, 32'h0);
    check(rd, 32'h80);
    wb(1'b1, 8'h30, 32'hFFFF_FFFF);
    wb(1'b0, 8'h30, 32'h0);
    check(rd, 32'h0);
    for (int k = 0; k < 10; k++) begin
      c = '{32'hFFFF_9000, 32'h0000_1000, 32'hFFFF_A000, 32'h84 + (xs() % 31) * 4,
            FMIN + xs() % (FMAX - FMIN + 1), 32'h80, 1'b0, 1'b0};
      case (k)
        1: c.len = 32'h0;
        2: c.stack = 32'h7C;
        3: c.emu = 1'b1;
        4: c.selfault = 1'b1;
        5: c.dest = 32'h0000_1000;
        6: c.freq = FMAX + 32'h1;
        7: c.faddr = 32'h0000_1040;
        8: c.src = 32'h0000_2000;
        9: c.len = 32'h80;
        default: ;
      endcase
      ram_emulation_i <= c.emu;
      sel_fault <= c.selfault;
      slow <= k[0];
      for (int i = 0; i < c.len / 4; i++) begin
        w = xs();
        DEV.ram[c.src + 4 * i] = w;
        exp_q.push_back(w);
      end
      wb(1'b1, fpdc_pkg::WB_DEST, c.dest);
      wb(1'b1, fpdc_pkg::WB_FADDR, c.faddr);
      wb(1'b1, fpdc_pkg::WB_SRC, c.src);
      wb(1'b1, fpdc_pkg::WB_LEN, c.len);
      wb(1'b1, fpdc_pkg::WB_FREQ, c.freq);
      wb(1'b1, fpdc_pkg::WB_UBR, 32'h0);
      wb(1'b1, fpdc_pkg::WB_STACK, c.stack);
      a0 = acks;
      p0 = DEV.passes;
      wb(1'b1, fpdc_pkg::WB_CTRL, 32'h1);
      n = 0;
      do begin
        wb(1'b0, fpdc_pkg::WB_STATUS, 32'h0);
        n++;
      end while (rd[1] !== 1'b1 && n < 2000);
      e = exp_err(c);
      w = {26'h0, e == fpdc_pkg::ERR_DEST, e, 2'b10};
      check({26'h0, rd[5:0]}, w);
      w = e == fpdc_pkg::ERR_SELECT ? 32'h04 : e == fpdc_pkg::ERR_DEST ? 32'hFF : 32'h00;
      if (e == fpdc_pkg::ERR_REFUSED) check(32'(acks - a0), 32'h0);
      else check({24'h0, rd[15:8]}, w);
      if (e != fpdc_pkg::ERR_REFUSED) check({24'h0, DEV.key}, 32'h0);
      if (e == fpdc_pkg::ERR_INIT || e == fpdc_pkg::ERR_PROG) begin
        wb(1'b0, fpdc_pkg::WB_RET, 32'h0);
        check(rd, 32'h1);
      end
      if (e == fpdc_pkg::ERR_NONE) begin
        check(32'(DEV.passes - p0), (c.len + 32'h7F) >> 7);
        for (int i = 0; i < ((c.len + 32'h7F) >> 7) * 32; i++) begin
          w = i < c.len / 4 ? exp_q[i] : fpdc_pkg::PAD_WORD;
          check(DEV.flash[c.faddr + 4 * i], w);
        end
      end
      exp_q.delete();
    end
    check(32'(DEV.viol), 32'h0);
    stop_test();
  end
endmodule // tb_top
bind fpdc_host fpdc_host_sva u_sva (.clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dev_req_o(dev_req_o), .dev_we_o(dev_we_o),
  .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_ack_i(dev_ack_i),
  .call_req_o(call_req_o), .call_addr_o(call_addr_o), .call_done_i(call_done_i),
  .ram_emulation_i(ram_emulation_i), .bus_hold_o(bus_hold_o));
